//--- hw/blvc_cfg_regs.sv
`timescale 1ns/1ps
// Link tuning, product data and extended config address registers
module blvc_cfg_regs
  import blvc_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // Configuration access port
  input  wire logic        cfg_req_in,
  input  wire logic        cfg_we_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_ack_out,
  // Hot swap strap level
  input  wire logic        hot_swap_en_in,
  // EEPROM port
  output logic             eep_req_out,
  output logic             eep_we_out,
  output logic [7:0]       eep_addr_out,
  output logic [31:0]      eep_wdata_out,
  input  wire logic        eep_ack_in,
  input  wire logic [31:0] eep_rdata_in,
  // Link training controls
  output logic             hot_reset_en_out,
  output logic             loopback_en_out,
  output logic             crosslink_en_out,
  output logic             direct_cfg_en_out,
  output logic             debug_sel_out,
  output logic [2:0]       lane_neg_tries_out,
  output logic [4:0]       ts1_count_out,
  output logic [15:0]      l1_enter_timer_out,
  output logic [9:0]       l0s_life_out,
  output logic [15:0]      l1_life_out,
  output logic [7:0]       cdr_fts_count_out,
  output logic [6:0]       l0s_exit_lat_out,
  output logic [6:0]       l1_exit_lat_out,
  output logic [23:0]      debounce_cycles_out,
  // Extended configuration target
  output logic             ext_cfg_en_out,
  output logic [7:0]       ext_bus_out,
  output logic [4:0]       ext_dev_out,
  output logic [2:0]       ext_func_out,
  output logic [3:0]       ext_xreg_out,
  output logic [7:0]       ext_reg_out
);
  // Refuse a millisecond count the debounce product cannot hold
  if (MS_CYCLES_P < 1 || MS_CYCLES_P > 65535) begin : g_chk
    $error("MS_CYCLES_P out of range");
  end

  typedef struct packed {
    logic [31:0] phy0;
    logic [31:0] phy1;
    logic [23:0] phy2;
    logic [7:0]  deb;
    logic [5:0]  vaddr;
    logic        vflag;
    logic        vbusy;
    logic        start;
    logic [31:0] vdata;
    logic [31:0] ext;
    logic [31:0] rdata;
    logic        ack;
    logic [23:0] deb_cyc;
  } blvc_regs_s;

  blvc_regs_s s_r;
  blvc_regs_s s_nxt;

  blvc_vpd_if vpd_if ();

  // Byte-enable merge of writable bits
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction : be_merge

  logic        wr;
  logic        rd;
  logic [31:0] vpd_word;
  logic [31:0] data_mask;

  assign wr = cfg_req_in & cfg_we_in;
  assign rd = cfg_req_in & ~cfg_we_in;

  assign vpd_word = {s_r.vflag, 7'h00, s_r.vaddr, 2'b00, CAP_NEXT, CAP_ID};

  // Data word locked while an EEPROM cycle runs
  assign data_mask = s_r.vbusy ? 32'h0000_0000 : 32'hffff_ffff;

  // Register update, cycle launch and read mux
  always_comb begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    s_nxt.ack   = cfg_req_in;
    s_nxt.rdata = 32'h0000_0000;
    if (wr) begin
      case (cfg_addr_in)
        OFF_PHY0: s_nxt.phy0 = be_merge(s_r.phy0, cfg_wdata_in, cfg_be_in, PHY0_WMASK);
        OFF_PHY1: s_nxt.phy1 = be_merge(s_r.phy1, cfg_wdata_in, cfg_be_in, PHY1_WMASK);
        OFF_PHY2: begin
          s_nxt.phy2 = 24'(be_merge({8'h00, s_r.phy2}, cfg_wdata_in, cfg_be_in,
                                    {8'h00, PHY2_WMASK}));
          if (hot_swap_en_in && cfg_be_in[3]) begin
            s_nxt.deb = cfg_wdata_in[31:DEB_LSB];
          end
        end
        OFF_VPD: begin
          if (!s_r.vbusy) begin
            if (cfg_be_in[2]) begin
              s_nxt.vaddr = cfg_wdata_in[VPD_ADDR_MSB:VPD_ADDR_LSB];
            end
            if (cfg_be_in[3]) begin
              s_nxt.vflag = cfg_wdata_in[VPD_FLAG_BIT];
              s_nxt.vbusy = 1'b1;
              s_nxt.start = 1'b1;
            end
          end
        end
        OFF_DATA: s_nxt.vdata = be_merge(s_r.vdata, cfg_wdata_in, cfg_be_in, data_mask);
        OFF_EXT:  s_nxt.ext = be_merge(s_r.ext, cfg_wdata_in, cfg_be_in, EXT_WMASK);
        default: ;
      endcase
    end
    if (vpd_if.done) begin
      s_nxt.vbusy = 1'b0;
      s_nxt.vflag = ~s_r.vflag;
      if (!s_r.vflag) begin
        s_nxt.vdata = vpd_if.rdata;
      end
    end
    if (rd) begin
      case (cfg_addr_in)
        OFF_PHY0: s_nxt.rdata = s_r.phy0;
        OFF_PHY1: s_nxt.rdata = s_r.phy1;
        OFF_PHY2: s_nxt.rdata = {s_r.deb, s_r.phy2};
        OFF_VPD:  s_nxt.rdata = vpd_word;
        OFF_DATA: s_nxt.rdata = s_r.vdata;
        OFF_EXT:  s_nxt.rdata = s_r.ext;
        default:  s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    s_nxt.deb_cyc = 24'((32'(s_r.deb) + 32'd1) * 32'(MS_CYCLES_P));
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r      <= '0;
      s_r.phy0 <= PHY0_RST;
      s_r.phy1 <= PHY1_RST;
      s_r.phy2 <= PHY2_RST;
      s_r.deb  <= DEB_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign vpd_if.addr  = {2'b00, s_r.vaddr} + VPD_EEP_BASE;
  assign vpd_if.start = s_r.start;
  assign vpd_if.write = s_r.vflag;
  assign vpd_if.wdata = s_r.vdata;

  blvc_vpd_seq u_seq (
    .core_clk_in   (core_clk_in),
    .rstn_in       (rstn_in),
    .vpd           (vpd_if.seq),
    .eep_req_out   (eep_req_out),
    .eep_we_out    (eep_we_out),
    .eep_addr_out  (eep_addr_out),
    .eep_wdata_out (eep_wdata_out),
    .eep_ack_in    (eep_ack_in),
    .eep_rdata_in  (eep_rdata_in)
  );

  // Bus answer
  assign cfg_rdata_out = s_r.rdata;
  assign cfg_ack_out   = s_r.ack;

  assign hot_reset_en_out  = s_r.phy0[0];
  assign loopback_en_out   = s_r.phy0[1];
  assign crosslink_en_out  = s_r.phy0[2];
  assign direct_cfg_en_out = s_r.phy0[3];
  assign debug_sel_out     = s_r.phy0[4];

  assign lane_neg_tries_out = s_r.phy0[7:5];
  assign ts1_count_out      = s_r.phy0[12:8];
  assign l1_enter_timer_out = s_r.phy0[31:16];

  assign l0s_life_out = s_r.phy1[9:0];
  assign l1_life_out  = s_r.phy1[31:16];

  assign cdr_fts_count_out = s_r.phy2[7:0];

  assign l0s_exit_lat_out = s_r.phy2[14:8];
  assign l1_exit_lat_out  = s_r.phy2[22:16];

  assign debounce_cycles_out = s_r.deb_cyc;

  assign ext_cfg_en_out = s_r.ext[EXT_EN_BIT];
  assign ext_bus_out    = s_r.ext[27:20];
  assign ext_dev_out    = s_r.ext[19:15];
  assign ext_func_out   = s_r.ext[14:12];
  assign ext_xreg_out   = s_r.ext[11:8];
  assign ext_reg_out    = s_r.ext[7:0];
endmodule : blvc_cfg_regs

//--- hw/blvc_pkg.sv
package blvc_pkg;
  // Register offsets
  localparam logic [7:0] OFF_PHY0 = 8'hcc;
  localparam logic [7:0] OFF_PHY1 = 8'hd0;
  localparam logic [7:0] OFF_PHY2 = 8'hd4;
  localparam logic [7:0] OFF_VPD  = 8'hd8;
  localparam logic [7:0] OFF_DATA = 8'hdc;
  localparam logic [7:0] OFF_EXT  = 8'he0;
  // Reset values
  localparam logic [31:0] PHY0_RST = 32'h0400_1060;
  localparam logic [31:0] PHY1_RST = 32'h0400_0271;
  localparam logic [23:0] PHY2_RST = 24'h19_0254;
  localparam logic [7:0]  DEB_RST  = 8'h00;
  // Writable bit masks
  localparam logic [31:0] PHY0_WMASK = 32'hffff_1fff;
  localparam logic [31:0] PHY1_WMASK = 32'hffff_03ff;
  localparam logic [23:0] PHY2_WMASK = 24'h7f_7fff;
  localparam logic [31:0] EXT_WMASK  = 32'h8fff_ffff;
  // Capability header
  localparam logic [7:0] CAP_ID   = 8'h03;
  localparam logic [7:0] CAP_NEXT = 8'hf0;
  // Field positions
  localparam int VPD_FLAG_BIT = 31;
  localparam int VPD_ADDR_LSB = 18;
  localparam int VPD_ADDR_MSB = 23;
  localparam int EXT_EN_BIT   = 31;
  localparam int DEB_LSB      = 24;
  localparam logic [7:0] VPD_EEP_BASE = 8'h40;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
endpackage : blvc_pkg

//--- hw/blvc_vpd_if.sv
`timescale 1ns/1ps
// Request and completion between register bank and EEPROM sequencer
interface blvc_vpd_if;
  logic        start;
  logic        write;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;
  modport regs (output start, write, addr, wdata, input done, rdata);
  modport seq  (input start, write, addr, wdata, output done, rdata);
endinterface : blvc_vpd_if

//--- hw/blvc_vpd_seq.sv
`timescale 1ns/1ps
// Runs one EEPROM cycle per start and reports completion
module blvc_vpd_seq
  import blvc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  blvc_vpd_if.seq          vpd,
  output logic             eep_req_out,
  output logic             eep_we_out,
  output logic [7:0]       eep_addr_out,
  output logic [31:0]      eep_wdata_out,
  input  wire logic        eep_ack_in,
  input  wire logic [31:0] eep_rdata_in
);
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_BUSY = 2'b01,
    SQ_DONE = 2'b10
  } blvc_sq_e;

  typedef struct packed {
    blvc_sq_e    st;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
  } blvc_sq_s;

  blvc_sq_s s_r;
  blvc_sq_s s_nxt;

  // Next-state logic
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      SQ_IDLE: begin
        if (vpd.start) begin
          s_nxt.st    = SQ_BUSY;
          s_nxt.req   = 1'b1;
          s_nxt.we    = vpd.write;
          s_nxt.addr  = vpd.addr;
          s_nxt.wdata = vpd.wdata;
        end
      end
      SQ_BUSY: begin
        if (eep_ack_in) begin
          s_nxt.st    = SQ_DONE;
          s_nxt.req   = 1'b0;
          s_nxt.rdata = eep_rdata_in;
          s_nxt.done  = 1'b1;
        end
      end
      SQ_DONE: s_nxt.st = SQ_IDLE;
      default: s_nxt.st = SQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign vpd.done      = s_r.done;
  assign vpd.rdata     = s_r.rdata;
  assign eep_req_out   = s_r.req;
  assign eep_we_out    = s_r.we;
  assign eep_addr_out  = s_r.addr;
  assign eep_wdata_out = s_r.wdata;
endmodule : blvc_vpd_seq

//--- test/blvc_cfg_regs_properties.sv
`timescale 1ns/1ps
// Port-level checks of the configuration register bank
module blvc_cfg_regs_properties
  import blvc_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  input wire logic        cfg_req_in,
  input wire logic        cfg_we_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [3:0]  cfg_be_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_ack_out,
  input wire logic        eep_req_out,
  input wire logic        eep_we_out,
  input wire logic [7:0]  eep_addr_out,
  input wire logic        eep_ack_in,
  input wire logic        ext_cfg_en_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Decoded accesses
  wire logic wr_vpd = cfg_req_in && cfg_we_in && cfg_addr_in == OFF_VPD && cfg_be_in[3];
  wire logic rd_vpd = cfg_req_in && !cfg_we_in && cfg_addr_in == OFF_VPD;
  wire logic rd_gap = cfg_req_in && !cfg_we_in && cfg_addr_in == 8'hec;
  wire logic wr_ext = cfg_req_in && cfg_we_in && cfg_addr_in == OFF_EXT && cfg_be_in[3];
  // Access handshake, read data and extended config enable writes
  property p_ack; cfg_req_in |=> cfg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_src; cfg_ack_out |-> $past(cfg_req_in); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_cap; $past(rd_vpd) |-> cfg_rdata_out[15:0] == {CAP_NEXT, CAP_ID}; endproperty
  a_cap: assert property (p_cap) else $error("capability header wrong");
  property p_gap; $past(rd_gap) |-> cfg_ack_out && cfg_rdata_out == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("reserved offset not zero");
  property p_ext; $changed(ext_cfg_en_out) |-> $past(wr_ext); endproperty
  a_ext: assert property (p_ext) else $error("ext enable changed unasked");
  // EEPROM cycle framing
  property p_launch; $rose(eep_req_out) |-> $past(wr_vpd, 2); endproperty
  a_launch: assert property (p_launch) else $error("cycle without launch");
  property p_hold;
    eep_req_out && !eep_ack_in |=> eep_req_out && $stable(eep_addr_out) && $stable(eep_we_out);
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  property p_drop; eep_req_out && eep_ack_in |=> !eep_req_out; endproperty
  a_drop: assert property (p_drop) else $error("request after ack");
  property p_addr; eep_req_out |-> eep_addr_out[7:6] == 2'h1; endproperty
  a_addr: assert property (p_addr) else $error("eeprom address off base");
  c_rd: cover property ($rose(eep_req_out) && !eep_we_out);
  c_wr: cover property ($rose(eep_req_out) && eep_we_out);
  c_gap: cover property ($past(rd_gap) && cfg_ack_out);
endmodule : blvc_cfg_regs_properties

bind blvc_cfg_regs blvc_cfg_regs_properties chk_u (.core_clk_in, .rstn_in, .cfg_req_in,
  .cfg_we_in, .cfg_addr_in, .cfg_be_in, .cfg_rdata_out, .cfg_ack_out, .eep_req_out,
  .eep_we_out, .eep_addr_out, .eep_ack_in, .ext_cfg_en_out);

//--- test/blvc_cfg_regs_tb_top.sv
`timescale 1ns/1ps
// Register access sequences against the bank and an EEPROM model
module blvc_cfg_regs_tb_top
  import blvc_pkg::*;
;
  logic        core_clk_in = '0, rstn_in = '0, cfg_req_in = '0, cfg_we_in = '0;
  logic        hot_swap_en_in = '0, cfg_ack_out, eep_req_out, eep_we_out, eep_ack_in;
  logic        hot_reset_en_out, loopback_en_out, crosslink_en_out, direct_cfg_en_out;
  logic        debug_sel_out, ext_cfg_en_out;
  logic [7:0]  cfg_addr_in = '0, eep_addr_out, ext_bus_out, cdr_fts_count_out, ext_reg_out;
  logic [3:0]  cfg_be_in = '0, stall = '0, ext_xreg_out;
  logic [31:0] cfg_wdata_in = '0, cfg_rdata_out, eep_wdata_out, eep_rdata_in, rd;
  logic [9:0]  l0s_life_out;
  logic [6:0]  l1_exit_lat_out, l0s_exit_lat_out;
  logic [2:0]  lane_neg_tries_out, ext_func_out;
  logic [4:0]  ts1_count_out, ext_dev_out;
  logic [15:0] l1_enter_timer_out, l1_life_out;
  logic [23:0] debounce_cycles_out;
  int          num_errors = 0, cmp_count = 0;

  blvc_cfg_regs #(.MS_CYCLES_P(4)) dut_u (.core_clk_in, .rstn_in, .cfg_req_in, .cfg_we_in,
    .cfg_addr_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_ack_out, .hot_swap_en_in,
    .eep_req_out, .eep_we_out, .eep_addr_out, .eep_wdata_out, .eep_ack_in, .eep_rdata_in,
    .hot_reset_en_out, .loopback_en_out, .crosslink_en_out, .direct_cfg_en_out, .debug_sel_out,
    .lane_neg_tries_out, .ts1_count_out, .l1_enter_timer_out, .l0s_life_out,
    .l1_life_out, .cdr_fts_count_out, .l0s_exit_lat_out, .l1_exit_lat_out,
    .debounce_cycles_out, .ext_cfg_en_out, .ext_bus_out, .ext_dev_out, .ext_func_out,
    .ext_xreg_out, .ext_reg_out);
  blvc_eep_model eep_u (.clk_in(core_clk_in), .rstn_in, .req_in(eep_req_out),
    .we_in(eep_we_out), .addr_in(eep_addr_out), .wdata_in(eep_wdata_out), .stall_in(stall),
    .ack_out(eep_ack_in), .rdata_out(eep_rdata_in));

  // Clock and hang guard
  initial forever #10 core_clk_in = ~core_clk_in;
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One access: pulse request, take answer at the ack edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge core_clk_in);
    cfg_req_in <= 1'b1;
    cfg_we_in <= w;
    cfg_addr_in <= a;
    cfg_be_in <= b;
    cfg_wdata_in <= d;
    @(posedge core_clk_in);
    cfg_req_in <= 1'b0;
    @(posedge core_clk_in);
    chk("ack", {31'h0, cfg_ack_out}, 32'h1);
    rd = cfg_rdata_out;
  endtask : acc
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 4'hf, 32'h0);
    chk(n, rd, e);
  endtask : rdc
  task automatic poll(input logic f);
    for (int i = 0; i < 40; i++) begin
      acc(1'b0, OFF_VPD, 4'hf, 32'h0);
      if (rd[31] === f) break;
    end
  endtask : poll
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rdc("phy0", OFF_PHY0, PHY0_RST);
    rdc("phy1", OFF_PHY1, PHY1_RST);
    rdc("phy2", OFF_PHY2, {DEB_RST, PHY2_RST});
    rdc("cap", OFF_VPD, 32'h0000_f003);
    rdc("data", OFF_DATA, 32'h0);
    rdc("ext", OFF_EXT, 32'h0);
    rdc("gap", 8'hec, 32'h0);
    chk("fts", {24'h0, cdr_fts_count_out}, 32'h54);
    chk("l0s", {22'h0, l0s_life_out}, 32'h271);
    chk("l1x", {25'h0, l1_exit_lat_out}, 32'h19);
    chk("deb", {8'h0, debounce_cycles_out}, 32'h4);
    chk("trn", {24'h0, lane_neg_tries_out, ts1_count_out}, 32'h70);
    chk("l1e", {16'h0, l1_enter_timer_out}, 32'h400);
    chk("l1l", {16'h0, l1_life_out}, 32'h400);
    chk("l0x", {25'h0, l0s_exit_lat_out}, 32'h2);
    acc(1'b1, OFF_PHY0, 4'hf, '1);
    chk("ctl", {27'h0, debug_sel_out, direct_cfg_en_out, crosslink_en_out, loopback_en_out,
                hot_reset_en_out}, 32'h1f);
    acc(1'b1, OFF_PHY0, 4'h1, 32'h0);
    rdc("phy0", OFF_PHY0, PHY0_WMASK & 32'hffff_ff00);
    chk("ctl", {31'h0, hot_reset_en_out | debug_sel_out}, 32'h0);
    acc(1'b1, OFF_PHY2, 4'hf, '1);
    rdc("phy2", OFF_PHY2, {DEB_RST, PHY2_WMASK});
    hot_swap_en_in <= 1'b1;
    acc(1'b1, OFF_PHY2, 4'hf, '1);
    rdc("phy2", OFF_PHY2, {8'hff, PHY2_WMASK});
    chk("deb", {8'h0, debounce_cycles_out}, 32'h400);
    acc(1'b1, OFF_EXT, 4'hf, '1);
    rdc("ext", OFF_EXT, EXT_WMASK);
    chk("exten", {23'h0, ext_cfg_en_out, ext_bus_out}, 32'h1ff);
    chk("extf", {12'h0, ext_dev_out, ext_func_out, ext_xreg_out, ext_reg_out}, 32'hfffff);
    acc(1'b1, OFF_EXT, 4'h8, 32'h0);
    chk("exten", {23'h0, ext_cfg_en_out, ext_bus_out}, 32'h00f);
    // Slow write cycle with a refused relaunch, then slow read back
    stall <= 4'hf;
    acc(1'b1, OFF_DATA, 4'hf, 32'h1234_5678);
    acc(1'b1, OFF_VPD, 4'hf, 32'h8014_0000);
    acc(1'b1, OFF_VPD, 4'hf, 32'h0000_0000);
    acc(1'b1, OFF_DATA, 4'hf, 32'hdead_beef);
    rdc("busy", OFF_VPD, 32'h8014_f003);
    poll(1'b0);
    chk("wdone", rd, 32'h0014_f003);
    rdc("dlock", OFF_DATA, 32'h1234_5678);
    // Clear the data word so the read back must come from the EEPROM
    acc(1'b1, OFF_DATA, 4'hf, 32'h0000_0000);
    acc(1'b1, OFF_VPD, 4'hc, 32'h0014_0000);
    rdc("rbusy", OFF_VPD, 32'h0014_f003);
    poll(1'b1);
    chk("rdone", rd, 32'h8014_f003);
    rdc("rdata", OFF_DATA, 32'h1234_5678);
    acc(1'b1, OFF_DATA, 4'h1, 32'h0000_00aa);
    rdc("part", OFF_DATA, 32'h1234_56aa);
    // Prompt read at the top address
    stall <= 4'h0;
    acc(1'b1, OFF_VPD, 4'hf, 32'h00fc_0000);
    poll(1'b1);
    rdc("top", OFF_DATA, 32'hc0de_007f);
    report_and_stop();
  end
endmodule : blvc_cfg_regs_tb_top

//--- test/blvc_eep_model.sv
`timescale 1ns/1ps
// Word-wide EEPROM answering after a chosen number of stall cycles
module blvc_eep_model (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  stall_in,
  output logic             ack_out,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [256];
  logic [3:0]  wait_r;
  logic        done_r;
  // Each word starts tagged with its own location
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {24'hc0de00, 8'(i)};
    end
  end
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_r <= 4'h0;
      done_r <= 1'b0;
      ack_out <= 1'b0;
      rdata_out <= 32'h0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out; // Data wanders when not answering
      if (!req_in) begin
        wait_r <= 4'h0;
        done_r <= 1'b0;
      end else if (!done_r && wait_r == stall_in) begin
        ack_out <= 1'b1;
        done_r <= 1'b1;
        if (we_in) mem[addr_in] <= wdata_in;
        else rdata_out <= mem[addr_in];
      end else if (!done_r) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : blvc_eep_model
